/* hw/imr_i2c_master_rx.sv */
// Two-wire bus master receive sequencer with register-side and link-side domains
//
// How it works
// - After reset the block is idle in slave mode until a start is requested.
// - A start is taken when the bus is free or the block is already master; it sets master mode.
// - Issued start sets the start-sent flag; irq follows if events are enabled.
// - Status one read then data write clears start-sent and sends the byte.
// - Ten-bit header sent sets header-sent; status one read then write clears it.
// - Ten-bit read: header dir 0, low address, restart, header dir 1.
// - A seven-bit address byte always goes out with its read bit set.
// - Address done sets address-sent; status one then status two clears it.
// - Ten-bit read repeats start, header and address-sent after first clear.
// - Received bits shift in, land in the data register, set receive-not-empty.
// - With acknowledge enabled each received byte is acknowledged low.
// - Data read returns the byte and clears receive-not-empty.
// - Last byte gets a not-acknowledge, then stop or repeated start follows.
// - Acknowledge off: byte is not acknowledged, flagged, then SCL is held until a stop or start is requested.
// - SCL is held low while start, address or header events are pending.
// - After the stop the block leaves master mode by itself.
`timescale 1ns/1ps
module imr_i2c_master_rx
  import imr_pkg::*;
#(
  parameter int QUARTER_CYCLES = QUARTER_CYCLES_DEF
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       linkClk,
  input  wire logic       startRequest,
  input  wire logic       stopRequest,
  input  wire logic       acknowledgeEnable,
  input  wire logic       eventIrqEnable,
  input  wire logic       status1Read,
  input  wire logic       status2Read,
  input  wire logic       dataWrite,
  input  wire logic [7:0] dataWriteValue,
  input  wire logic       dataRead,
  output logic      [7:0] readData,
  output logic            startSentFlag,
  output logic            headerSentFlag,
  output logic            addressSentFlag,
  output logic            receiveNotEmptyFlag,
  output logic            masterModeStatus,
  output logic            busBusy,
  output logic            eventIrq,
  input  wire logic       sclIn,
  output logic            sclOut,
  output logic            sclOe,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe
);

  localparam logic [QCNT_W-1:0] QLAST = QCNT_W'(QUARTER_CYCLES - 1);

  imr_ctl_t c_r;
  imr_ctl_t c_nxt;
  imr_lnk_t l_r;
  imr_lnk_t l_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Register-side domain

  always_comb begin
    logic evStart;
    logic evHdr;
    logic evAddr;
    logic evByte;
    logic evStop;
    logic clrStart;
    logic clrHdr;
    logic clrAddr;
    evStart  = 1'b0;
    evHdr    = 1'b0;
    evAddr   = 1'b0;
    evByte   = 1'b0;
    evStop   = 1'b0;
    clrStart = 1'b0;
    clrHdr   = 1'b0;
    clrAddr  = 1'b0;
    c_nxt = c_r;
    c_nxt.evStartS = {c_r.evStartS[1:0], l_r.evStartT};
    c_nxt.evHdrS   = {c_r.evHdrS[1:0], l_r.evHdrT};
    c_nxt.evAddrS  = {c_r.evAddrS[1:0], l_r.evAddrT};
    c_nxt.evByteS  = {c_r.evByteS[1:0], l_r.evByteT};
    c_nxt.evStopS  = {c_r.evStopS[1:0], l_r.evStopT};
    c_nxt.busyS    = {c_r.busyS[0], l_r.busy};
    evStart = c_r.evStartS[1] ^ c_r.evStartS[2];
    evHdr   = c_r.evHdrS[1] ^ c_r.evHdrS[2];
    evAddr  = c_r.evAddrS[1] ^ c_r.evAddrS[2];
    evByte  = c_r.evByteS[1] ^ c_r.evByteS[2];
    evStop  = c_r.evStopS[1] ^ c_r.evStopS[2];

    if (startRequest && (!c_r.busyS[1] || c_r.master)) begin
      c_nxt.master    = 1'b1;
      c_nxt.reqStartT = ~c_r.reqStartT;
    end
    if (stopRequest && c_r.master) begin
      c_nxt.reqStopT = ~c_r.reqStopT;
    end
    if (evStop) begin
      c_nxt.master = 1'b0;
    end

    if (status1Read && (c_r.startSent || c_r.hdrSent || c_r.addrSent)) begin
      c_nxt.seen1 = 1'b1;
    end
    clrStart = c_r.startSent && c_r.seen1 && dataWrite;
    clrHdr   = c_r.hdrSent && c_r.seen1 && dataWrite;
    clrAddr  = c_r.addrSent && c_r.seen1 && status2Read;
    if (clrStart || clrHdr) begin
      c_nxt.txT    = ~c_r.txT;
      c_nxt.txByte = dataWriteValue;
      if (clrStart && dataWriteValue[7:3] != TEN_BIT_PREFIX) begin
        c_nxt.txByte[0] = 1'b1;
      end
    end
    if (clrAddr) begin
      c_nxt.relT = ~c_r.relT;
    end
    if (clrStart || clrHdr || clrAddr) begin
      c_nxt.seen1 = 1'b0;
    end

    // Hardware set wins over a same-cycle clear
    c_nxt.startSent = (c_r.startSent && !clrStart) || evStart;
    c_nxt.hdrSent   = (c_r.hdrSent && !clrHdr) || evHdr;
    c_nxt.addrSent  = (c_r.addrSent && !clrAddr) || evAddr;
    c_nxt.rxNe      = (c_r.rxNe && !dataRead) || evByte;
    if (evByte) begin
      c_nxt.rxData = l_r.rxByte;
    end
    c_nxt.irq = eventIrqEnable && (c_nxt.startSent || c_nxt.hdrSent || c_nxt.addrSent);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      c_r <= '0;
    end else begin
      c_r <= c_nxt;
    end
  end

  assign readData            = c_r.rxData;
  assign startSentFlag       = c_r.startSent;
  assign headerSentFlag      = c_r.hdrSent;
  assign addressSentFlag     = c_r.addrSent;
  assign receiveNotEmptyFlag = c_r.rxNe;
  assign masterModeStatus    = c_r.master;
  assign busBusy             = c_r.busyS[1];
  assign eventIrq            = c_r.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Link-side domain

  always_comb begin
    logic timed;
    logic stall;
    logic tick;
    logic endBit;
    logic sampleNow;
    logic isHdr;
    timed     = 1'b0;
    stall     = 1'b0;
    tick      = 1'b0;
    endBit    = 1'b0;
    sampleNow = 1'b0;
    isHdr     = 1'b0;
    l_nxt = l_r;
    l_nxt.rstS   = {l_r.rstS[0], reset};
    l_nxt.sclS   = {l_r.sclS[0], sclIn};
    l_nxt.sdaS   = {l_r.sdaS[0], sdaIn};
    l_nxt.ackS   = {l_r.ackS[0], acknowledgeEnable};
    l_nxt.startS = {l_r.startS[1:0], c_r.reqStartT};
    l_nxt.stopS  = {l_r.stopS[1:0], c_r.reqStopT};
    l_nxt.txS    = {l_r.txS[1:0], c_r.txT};
    l_nxt.relS   = {l_r.relS[1:0], c_r.relT};
    l_nxt.sdaP   = l_r.sdaS[1];

    // Bus activity watch for the busy indication
    if (l_r.sclS[1] && l_r.sdaP && !l_r.sdaS[1]) begin
      l_nxt.busy = 1'b1;
    end else if (l_r.sclS[1] && !l_r.sdaP && l_r.sdaS[1]) begin
      l_nxt.busy = 1'b0;
    end
    if (l_r.startS[1] ^ l_r.startS[2]) begin
      l_nxt.pendStart = 1'b1;
    end
    if (l_r.stopS[1] ^ l_r.stopS[2]) begin
      l_nxt.pendStop = 1'b1;
    end

    // Quarter-bit timing; a released SCL held low by a slave stalls it
    timed = l_r.state inside {LK_START, LK_SEND, LK_SLV_ACK, LK_RECV, LK_MST_ACK, LK_STOP};
    stall = !l_r.sclOe && !l_r.sclS[1];
    tick  = timed && !stall && l_r.qCnt == QLAST;
    endBit    = tick && l_r.phase == PHASE_LAST;
    sampleNow = tick && l_r.phase == PHASE_SAMPLE;
    if (timed && !stall) begin
      l_nxt.qCnt = tick ? '0 : l_r.qCnt + 1'b1;
      if (tick) begin
        l_nxt.phase = l_r.phase + 1'b1;
      end
    end

    unique case (l_r.state)
      LK_IDLE: begin
        if (l_r.pendStart) begin
          l_nxt.pendStart = 1'b0;
          l_nxt.state     = LK_START;
        end
      end
      LK_HOLD: begin
        if (l_r.pendStart) begin
          l_nxt.pendStart = 1'b0;
          l_nxt.state     = LK_START;
        end else if (l_r.pendStop) begin
          l_nxt.pendStop = 1'b0;
          l_nxt.state    = LK_STOP;
        end
      end
      LK_START: begin
        if (endBit) begin
          l_nxt.evStartT = ~l_r.evStartT;
          l_nxt.owned    = 1'b1;
          l_nxt.state    = LK_WAIT_TX;
        end
      end
      LK_WAIT_TX: begin
        if (l_r.txS[1] ^ l_r.txS[2]) begin
          l_nxt.shift    = c_r.txByte;
          l_nxt.lastByte = c_r.txByte;
          l_nxt.bitCnt   = '0;
          l_nxt.state    = LK_SEND;
        end
      end
      LK_SEND: begin
        if (endBit) begin
          l_nxt.shift  = {l_r.shift[6:0], 1'b0};
          l_nxt.bitCnt = l_r.bitCnt + 1'b1;
          if (l_r.bitCnt == LAST_BIT) begin
            l_nxt.state = LK_SLV_ACK;
          end
        end
      end
      LK_SLV_ACK: begin
        if (endBit) begin
          isHdr = l_r.lastByte[7:3] == TEN_BIT_PREFIX;
          if (isHdr && !l_r.lastByte[0] && !l_r.hdrDone) begin
            l_nxt.evHdrT  = ~l_r.evHdrT;
            l_nxt.hdrDone = 1'b1;
            l_nxt.state   = LK_WAIT_TX;
          end else begin
            l_nxt.evAddrT = ~l_r.evAddrT;
            l_nxt.readDir = l_r.lastByte[0] && !l_r.hdrDone;
            l_nxt.hdrDone = 1'b0;
            l_nxt.state   = LK_WAIT_ADDR;
          end
        end
      end
      LK_WAIT_ADDR: begin
        if (l_r.relS[1] ^ l_r.relS[2]) begin
          l_nxt.bitCnt = '0;
          l_nxt.state  = l_r.readDir ? LK_RECV : LK_HOLD;
        end
      end
      LK_RECV: begin
        if (sampleNow) begin
          l_nxt.shift = {l_r.shift[6:0], l_r.sdaS[1]};
        end
        if (endBit) begin
          l_nxt.bitCnt = l_r.bitCnt + 1'b1;
          if (l_r.bitCnt == LAST_BIT) begin
            l_nxt.rxByte  = l_r.shift;
            l_nxt.evByteT = ~l_r.evByteT;
            l_nxt.nack    = !l_r.ackS[1];
            l_nxt.state   = LK_MST_ACK;
          end
        end
      end
      LK_MST_ACK: begin
        if (endBit) begin
          if (!l_r.nack) begin
            l_nxt.state = LK_RECV;
          end else if (l_r.pendStop) begin
            l_nxt.pendStop = 1'b0;
            l_nxt.state    = LK_STOP;
          end else if (l_r.pendStart) begin
            l_nxt.pendStart = 1'b0;
            l_nxt.state     = LK_START;
          end else begin
            l_nxt.state = LK_HOLD;
          end
        end
      end
      LK_STOP: begin
        if (endBit) begin
          l_nxt.evStopT = ~l_r.evStopT;
          l_nxt.owned   = 1'b0;
          l_nxt.state   = LK_IDLE;
        end
      end
      default: begin
        l_nxt.state = LK_IDLE;
      end
    endcase

    // Pin drive, registered: high enable pulls the line low
    unique case (l_r.state)
      LK_IDLE: begin
        l_nxt.sclOe = 1'b0;
        l_nxt.sdaOe = 1'b0;
      end
      LK_START: begin
        l_nxt.sclOe = l_r.phase == PHASE_LAST || (l_r.phase == 2'h0 && l_r.owned);
        l_nxt.sdaOe = l_r.phase >= PHASE_SAMPLE;
      end
      LK_WAIT_TX: begin
        l_nxt.sclOe = 1'b1;
        l_nxt.sdaOe = 1'b1;
      end
      LK_WAIT_ADDR, LK_HOLD: begin
        l_nxt.sclOe = 1'b1;
        l_nxt.sdaOe = 1'b0;
      end
      // SDA moves only once SCL is already pulled low, never on its falling edge
      LK_SEND: begin
        l_nxt.sclOe = l_r.phase < PHASE_SAMPLE;
        l_nxt.sdaOe = l_r.sclOe ? !l_r.shift[7] : l_r.sdaOe;
      end
      LK_SLV_ACK, LK_RECV: begin
        l_nxt.sclOe = l_r.phase < PHASE_SAMPLE;
        l_nxt.sdaOe = l_r.sclOe ? 1'b0 : l_r.sdaOe;
      end
      LK_MST_ACK: begin
        l_nxt.sclOe = l_r.phase < PHASE_SAMPLE;
        l_nxt.sdaOe = l_r.sclOe ? !l_r.nack : l_r.sdaOe;
      end
      LK_STOP: begin
        l_nxt.sclOe = l_r.phase == 2'h0;
        if (l_r.phase == PHASE_LAST) begin
          l_nxt.sdaOe = 1'b0;
        end else begin
          l_nxt.sdaOe = l_r.sclOe ? 1'b1 : l_r.sdaOe;
        end
      end
      default: begin
        l_nxt.sclOe = 1'b0;
        l_nxt.sdaOe = 1'b0;
      end
    endcase

    if (l_r.rstS[1]) begin
      l_nxt.state     = LK_IDLE;
      l_nxt.phase     = '0;
      l_nxt.qCnt      = '0;
      l_nxt.bitCnt    = '0;
      l_nxt.shift     = '0;
      l_nxt.lastByte  = '0;
      l_nxt.rxByte    = '0;
      l_nxt.hdrDone   = 1'b0;
      l_nxt.readDir   = 1'b0;
      l_nxt.nack      = 1'b0;
      l_nxt.owned     = 1'b0;
      l_nxt.pendStart = 1'b0;
      l_nxt.pendStop  = 1'b0;
      l_nxt.busy      = 1'b0;
      l_nxt.evStartT  = 1'b0;
      l_nxt.evHdrT    = 1'b0;
      l_nxt.evAddrT   = 1'b0;
      l_nxt.evByteT   = 1'b0;
      l_nxt.evStopT   = 1'b0;
      l_nxt.sclOe     = 1'b0;
      l_nxt.sdaOe     = 1'b0;
    end
  end

  // Asserted at once so no unknown toggle reaches the register side
  always_ff @(posedge linkClk or posedge reset) begin
    if (reset) begin
      l_r <= '0;
    end else begin
      l_r <= l_nxt;
    end
  end

  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;
  assign sclOe  = l_r.sclOe;
  assign sdaOe  = l_r.sdaOe;

endmodule

/* hw/imr_pkg.sv */
// Constants and types shared by the two-wire master receive sequencer
package imr_pkg;

  // Link clock period and bus quarter-bit time
  localparam int LINK_PERIOD_PS     = 30000;
  localparam int QUARTER_NS         = 2500;
  localparam int QUARTER_CYCLES_DEF = (QUARTER_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
  localparam int QCNT_W             = 12;

  // Ten-bit header prefix 11110
  localparam logic [4:0] TEN_BIT_PREFIX = 5'h1e;
  localparam logic [1:0] PHASE_SAMPLE   = 2'h2;
  localparam logic [1:0] PHASE_LAST     = 2'h3;
  localparam logic [2:0] LAST_BIT       = 3'h7;

  typedef enum logic [3:0] {
    LK_IDLE,
    LK_START,
    LK_WAIT_TX,
    LK_SEND,
    LK_SLV_ACK,
    LK_WAIT_ADDR,
    LK_RECV,
    LK_MST_ACK,
    LK_HOLD,
    LK_STOP
  } imr_lstate_t;

  // Register-side state
  typedef struct packed {
    logic [2:0] evStartS;
    logic [2:0] evHdrS;
    logic [2:0] evAddrS;
    logic [2:0] evByteS;
    logic [2:0] evStopS;
    logic [1:0] busyS;
    logic       master;
    logic       startSent;
    logic       hdrSent;
    logic       addrSent;
    logic       rxNe;
    logic       seen1;
    logic       irq;
    logic       reqStartT;
    logic       reqStopT;
    logic       txT;
    logic       relT;
    logic [7:0] txByte;
    logic [7:0] rxData;
  } imr_ctl_t;

  // Link-side state
  typedef struct packed {
    imr_lstate_t       state;
    logic [1:0]        phase;
    logic [QCNT_W-1:0] qCnt;
    logic [2:0]        bitCnt;
    logic [7:0]        shift;
    logic [7:0]        lastByte;
    logic [7:0]        rxByte;
    logic              hdrDone;
    logic              readDir;
    logic              nack;
    logic              owned;
    logic              pendStart;
    logic              pendStop;
    logic              busy;
    logic [2:0]        startS;
    logic [2:0]        stopS;
    logic [2:0]        txS;
    logic [2:0]        relS;
    logic [1:0]        ackS;
    logic [1:0]        sclS;
    logic [1:0]        sdaS;
    logic [1:0]        rstS;
    logic              sdaP;
    logic              evStartT;
    logic              evHdrT;
    logic              evAddrT;
    logic              evByteT;
    logic              evStopT;
    logic              sclOe;
    logic              sdaOe;
  } imr_lnk_t;

endpackage

/* test/imr_i2c_master_rx_checker.sv */
// Port-level assertions for the master receive sequencer
`timescale 1ns/1ps
module imr_i2c_master_rx_checker
  import imr_pkg::*;
(
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       startRequest,
  input wire logic       eventIrqEnable,
  input wire logic       status1Read,
  input wire logic       status2Read,
  input wire logic       dataWrite,
  input wire logic       dataRead,
  input wire logic [7:0] readData,
  input wire logic       startSentFlag,
  input wire logic       headerSentFlag,
  input wire logic       addressSentFlag,
  input wire logic       receiveNotEmptyFlag,
  input wire logic       masterModeStatus,
  input wire logic       busBusy,
  input wire logic       eventIrq,
  input wire logic       sclOe,
  input wire logic       sdaOe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  a_idle_quiet: assert property (
    !busBusy && !masterModeStatus |-> !sclOe && !sdaOe) else $error("Idle drives bus");
  a_start_mode: assert property (
    startRequest && !busBusy |-> ##[1:3] masterModeStatus) else $error("No master mode");
  a_irq_start: assert property (
    $rose(startSentFlag) && eventIrqEnable |-> ##[0:2] eventIrq) else $error("No irq");
  a_start_clear: assert property (
    startSentFlag && status1Read ##[1:3] dataWrite |-> ##[1:2] !startSentFlag)
    else $error("Start flag kept");
  a_hdr_clear: assert property (
    headerSentFlag && status1Read ##[1:3] dataWrite |-> ##[1:2] !headerSentFlag)
    else $error("Header flag kept");
  a_addr_clear: assert property (
    addressSentFlag && status1Read ##[1:3] status2Read |-> ##[1:2] !addressSentFlag)
    else $error("Address flag kept");
  a_data_stands: assert property (
    receiveNotEmptyFlag && $past(receiveNotEmptyFlag) |-> $stable(readData))
    else $error("Data moved");
  a_rx_clear: assert property (
    dataRead && receiveNotEmptyFlag |-> ##[1:2] !receiveNotEmptyFlag)
    else $error("Rx flag kept");
  a_scl_held: assert property (
    (startSentFlag || headerSentFlag || addressSentFlag) [*8] |-> sclOe)
    else $error("Clock not held");
  a_stop_exit: assert property (
    $fell(busBusy) |-> ##[0:10] !masterModeStatus) else $error("Master mode kept");
  c_header: cover property ($rose(headerSentFlag));
  c_read: cover property (dataRead && receiveNotEmptyFlag);
  c_exit: cover property ($fell(masterModeStatus));
endmodule
bind imr_i2c_master_rx imr_i2c_master_rx_checker chk_u (.*);

/* test/imr_i2c_master_rx_tb.sv */
// Self-checking bench for the master receive sequencer
`timescale 1ns/1ps
module imr_i2c_master_rx_tb
  import imr_pkg::*;
;
  logic       clk, linkClk, reset, acknowledge_enable, irqEn;
  logic [5:0] pul;
  logic [7:0] dv, rdData, seen;
  logic       ssf, hsf, asf, rnf, mms, busBusy, eventIrq, sclOe, sdaOe, sdaOeS;
  int         err_count, total_checks, cyc, seed, idx;
  wire        scl = !sclOe;
  wire        sda = !(sdaOe || sdaOeS);
  wire  [4:0] fl = {mms, rnf, asf, hsf, ssf};
  imr_i2c_master_rx #(.QUARTER_CYCLES(4)) dut_u (
    .clk(clk), .reset(reset), .linkClk(linkClk), .startRequest(pul[0]),
    .stopRequest(pul[1]), .acknowledgeEnable(acknowledge_enable), .eventIrqEnable(irqEn),
    .status1Read(pul[2]), .status2Read(pul[3]), .dataWrite(pul[4]),
    .dataWriteValue(dv), .dataRead(pul[5]), .readData(rdData), .startSentFlag(ssf),
    .headerSentFlag(hsf), .addressSentFlag(asf), .receiveNotEmptyFlag(rnf),
    .masterModeStatus(mms), .busBusy(busBusy), .eventIrq(eventIrq), .sclIn(scl),
    .sclOut(), .sclOe(sclOe), .sdaIn(sda), .sdaOut(), .sdaOe(sdaOe));
  imr_slave_model slv_u (.scl(scl), .sda(sda), .sdaOe(sdaOeS), .seenByte(seen));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    linkClk = 1'b0;
    #7;
    forever #15 linkClk = ~linkClk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task test_done();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      test_done();
    end
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task pulse(input int b, input logic [7:0] v = 8'h00);
    @(posedge clk);
    pul <= 6'h01 << b;
    dv <= v;
    @(posedge clk);
    pul <= 6'h00;
  endtask
  task waitF(input int b, input logic v);
    int n;
    n = 0;
    while (fl[b] !== v && n < 20000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(fl[b], v);
  endtask
  function logic [7:0] expByte(input int k);
    return 8'h5c + 8'(k) * 8'h3b;
  endfunction
  task xfer(input logic ten, input logic [9:0] a, input int n);
    logic [7:0] h;
    h = {TEN_BIT_PREFIX, a[9:8], 1'b0};
    pulse(0);
    waitF(0, 1'b1);
    chk(mms, 1'b1);
    repeat (20) @(posedge clk);
    chk({sclOe, eventIrq}, {1'b1, irqEn});
    pulse(2);
    pulse(4, ten ? h : {a[6:0], 1'b0});
    waitF(0, 1'b0);
    if (ten) begin
      waitF(1, 1'b1);
      chk(seen, h);
      pulse(2);
      pulse(4, a[7:0]);
      waitF(1, 1'b0);
    end
    waitF(2, 1'b1);
    chk(seen, ten ? a[7:0] : {a[6:0], 1'b1});
    pulse(2);
    pulse(3);
    waitF(2, 1'b0);
    if (ten) begin
      pulse(0);
      waitF(0, 1'b1);
      pulse(2);
      pulse(4, h | 8'h01);
      waitF(2, 1'b1);
      chk(seen, h | 8'h01);
      pulse(2);
      pulse(3);
      waitF(2, 1'b0);
    end
    if (n == 1) begin
      acknowledge_enable <= 1'b0;
      pulse(1);
    end
    for (int i = 0; i < n; i++) begin
      waitF(3, 1'b1);
      chk(rdData, expByte(idx));
      idx++;
      if (i == n - 2) acknowledge_enable <= 1'b0;
      pulse(5);
      waitF(3, 1'b0);
      if (i == n - 2) pulse(1);
    end
    waitF(4, 1'b0);
    repeat (20) @(posedge clk);
    chk({sclOe, sdaOe, busBusy}, 8'h00);
    acknowledge_enable <= 1'b1;
    $display("transfer done ten %0d bytes %0d", ten, n);
  endtask
  initial begin
    seed = 32'h5725d6fd;
    {pul, dv, acknowledge_enable, irqEn, reset, cyc, err_count, total_checks, idx} = '0;
    reset = 1'b1;
    acknowledge_enable = 1'b1;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    repeat (20) @(posedge clk);
    chk({mms, sclOe, sdaOe, busBusy}, 8'h00);
    pulse(1);
    repeat (10) @(posedge clk);
    chk({mms, sdaOe}, 8'h00);
    xfer(1'b0, 10'h05a, 1);
    irqEn <= 1'b1;
    xfer(1'b1, 10'h2c3, 2);
    repeat (6) begin
      irqEn <= 1'($random(seed));
      xfer(1'($random(seed)), 10'({$random(seed)}) & 10'h3bf, 1 + int'({$random(seed)} % 4));
    end
    test_done();
  end
endmodule

/* test/imr_slave_model.sv */
// Behavioural bus slave answering reads with a counting byte stream
`timescale 1ns/1ps
module imr_slave_model (
  input  wire logic       scl,
  input  wire logic       sda,
  output logic            sdaOe,
  output logic      [7:0] seenByte
);
  logic [7:0] sh = 8'h00;
  logic [7:0] tx = 8'h00;
  logic [3:0] n = 4'h0;
  logic       rd = 1'b0;
  logic       first = 1'b0;
  logic       act = 1'b0;
  int         k = 0;
  initial sdaOe = 1'b0;
  initial seenByte = 8'h00;
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      act = 1'b1;
      first = 1'b1;
      rd = 1'b0;
      n = 4'h0;
      sdaOe = 1'b0;
    end
  end
  always @(posedge sda) begin
    if (scl === 1'b1) act = 1'b0;
  end
  always @(posedge scl) begin
    if (act) begin
      if (n < 4'h8) sh = {sh[6:0], sda};
      else if (rd && sda) act = 1'b0; // Nack: both lines left released
      n = n + 4'h1;
    end
  end
  always @(negedge scl) begin
    if (act && n == 4'h8 && !rd) begin
      sdaOe = 1'b1;
      seenByte = sh;
      rd = first && sh[0];
      first = 1'b0;
    end else if (act && n == 4'h8) begin
      sdaOe = 1'b0;
    end else if (act && n == 4'h9) begin
      n = 4'h0;
      tx = 8'h5c + 8'(k) * 8'h3b;
      sdaOe = rd && !tx[7];
      if (rd) k++;
    end else if (act && rd && n != 4'h0) begin
      sdaOe = !tx[3'(4'h7 - n)];
    end
  end
endmodule
